/* File: src/imss_pkg.sv */
// Constants and types shared by the microframe schedule and status block.
// Assumes a single 200 MHz clock and an AXI4-Lite register bus.
package imss_pkg;
	localparam int IMSS_ADDR_W = 8;
	localparam int IMSS_NUM_UF = 8;
	localparam int IMSS_UF_W = 3;
	localparam int IMSS_CNT_W = 12;
	localparam int IMSS_OUT_W = 3;
	localparam int IMSS_FRM_W = 5;
	localparam int IMSS_INT_W = 4;
	////////////////////////////////////////////////////////////////////////////////
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_FRAME = 8'h04;
	localparam logic [7:0] OFS_SCHED = 8'h08;
	localparam logic [7:0] OFS_CNT01 = 8'h0c;
	localparam logic [7:0] OFS_CNT23 = 8'h10;
	localparam logic [7:0] OFS_CNT45 = 8'h14;
	localparam logic [7:0] OFS_CNT67 = 8'h18;
	localparam logic [7:0] OFS_INT_STAT = 8'h1c;
	localparam logic [7:0] OFS_INT_MASK = 8'h20;
	////////////////////////////////////////////////////////////////////////////////
	localparam int CTRL_ACTIVE_BIT = 0;
	localparam int CTRL_TOKEN_IN_BIT = 1;
	localparam int CTRL_HALT_BIT = 2;
	localparam int FRAME_NUM_LSB = 3;
	localparam int FRAME_NUM_MSB = 7;
	localparam int SCHED_OUT_LSB = 8;
	localparam int OUT_ERR_BIT = 0;
	localparam int OUT_BABBLE_BIT = 1;
	localparam int OUT_UNDERRUN_BIT = 2;
	localparam int CNT_HI_LSB = 16;
	localparam int INT_DONE_BIT = 0;
	localparam int INT_ERR_BIT = 1;
	localparam int INT_HALT_BIT = 2;
	localparam int INT_FRAME_BIT = 3;
	////////////////////////////////////////////////////////////////////////////////
	localparam logic [7:0] RST_MASK = 8'h00;
	localparam logic [7:0] RST_FRAME = 8'h00;
	localparam logic [IMSS_INT_W-1:0] RST_INT_MASK = 4'h0;
	localparam logic [IMSS_OUT_W-1:0] RST_OUTCOME = 3'h0;
	localparam logic [IMSS_CNT_W-1:0] RST_COUNT = 12'h000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef enum logic [0:0] {
		IMSS_SEQ_IDLE = 1'b0,
		IMSS_SEQ_WAIT = 1'b1
	} imss_seq_e;
endpackage

/* File: src/imss_sched_if.sv */
// Carrier between the register side and the microframe sequencer.
// Assumes both ends run on ref_clk.
`timescale 1ns/1ps
interface imss_sched_if;
	import imss_pkg::*;
	logic active;
	logic token_in;
	logic frame_match;
	logic [7:0] mask;
	logic [IMSS_OUT_W-1:0] rec_outcome;
	logic [IMSS_CNT_W-1:0] rec_count;
	logic [IMSS_UF_W-1:0] rec_idx;
	logic rec_valid;
	logic rec_halt;

	modport regs (output active, token_in, frame_match, mask,
		input rec_outcome, rec_count, rec_idx, rec_valid, rec_halt);
	modport seq (input active, token_in, frame_match, mask,
		output rec_outcome, rec_count, rec_idx, rec_valid, rec_halt);
endinterface

/* File: src/imss_top.sv */
// Isochronous microframe schedule and status block with AXI4-Lite registers.
// Assumes link strobes come from logic on ref_clk; one transfer per start.
`timescale 1ns/1ps
module imss_top
	import imss_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [IMSS_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [IMSS_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic usb_sof,
	input wire logic [IMSS_UF_W-1:0] usb_uframe,
	input wire logic [IMSS_FRM_W-1:0] usb_frame_num,
	input wire logic xfer_done,
	input wire logic xfer_err,
	input wire logic xfer_babble,
	input wire logic xfer_underrun,
	input wire logic xfer_stall,
	input wire logic [IMSS_CNT_W-1:0] xfer_byte_count,
	output logic xfer_start,
	output logic [IMSS_UF_W-1:0] xfer_uframe,
	output logic xfer_is_in,
	output logic irq
);
	imss_sched_if sif ();

	////////////////////////////////////////////////////////////////////////////////
	// Bus handshake state
	logic aw_hold_reg, aw_hold_next;
	logic w_hold_reg, w_hold_next;
	logic [IMSS_ADDR_W-1:0] waddr_reg, waddr_next;
	logic [31:0] wdata_reg, wdata_next;
	logic [3:0] wstrb_reg, wstrb_next;
	logic awready_reg, awready_next;
	logic wready_reg, wready_next;
	logic bvalid_reg, bvalid_next;
	logic [1:0] bresp_reg, bresp_next;
	logic arready_reg, arready_next;
	logic rvalid_reg, rvalid_next;
	logic [1:0] rresp_reg, rresp_next;
	logic [31:0] rdata_reg, rdata_next;
	logic wr_en;
	logic [31:0] wmask;
	logic [31:0] wbits;

	////////////////////////////////////////////////////////////////////////////////
	// Register state
	logic active_reg, active_next;
	logic token_in_reg, token_in_next;
	logic halt_reg, halt_next;
	logic [7:0] frame_reg, frame_next;
	logic [7:0] mask_reg;
	logic [IMSS_INT_W-1:0] int_stat_reg, int_stat_next;
	logic [IMSS_INT_W-1:0] int_mask_reg, int_mask_next;
	logic irq_reg, irq_next;
	logic [IMSS_OUT_W-1:0] outcome_reg [IMSS_NUM_UF];
	logic [IMSS_CNT_W-1:0] count_reg [IMSS_NUM_UF];
	logic [IMSS_INT_W-1:0] int_event;
	logic [7:0] mask_sw_set;
	logic [7:0] mask_hw_clr;
	logic [23:0] outcome_flat;

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave
	always_comb begin
		aw_hold_next = aw_hold_reg;
		w_hold_next = w_hold_reg;
		waddr_next = waddr_reg;
		wdata_next = wdata_reg;
		wstrb_next = wstrb_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		rvalid_next = rvalid_reg;
		rresp_next = rresp_reg;
		rdata_next = rdata_reg;
		wr_en = 1'b0;
		if (s_axi_awvalid && awready_reg) begin
			aw_hold_next = 1'b1;
			waddr_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_reg) begin
			w_hold_next = 1'b1;
			wdata_next = s_axi_wdata;
			wstrb_next = s_axi_wstrb;
		end
		if (bvalid_reg && s_axi_bready) begin
			bvalid_next = 1'b0;
		end
		// Write commits only once both halves are in and the old response is gone
		if (aw_hold_reg && w_hold_reg && !bvalid_reg) begin
			wr_en = 1'b1;
			aw_hold_next = 1'b0;
			w_hold_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = addr_ok(waddr_reg) ? RESP_OKAY : RESP_DECERR;
		end
		if (rvalid_reg && s_axi_rready) begin
			rvalid_next = 1'b0;
		end
		if (s_axi_arvalid && arready_reg) begin
			rvalid_next = 1'b1;
			rresp_next = addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_DECERR;
			rdata_next = read_word(s_axi_araddr);
		end
		awready_next = !aw_hold_next && !bvalid_next;
		wready_next = !w_hold_next && !bvalid_next;
		arready_next = !rvalid_next;
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			aw_hold_reg <= 1'b0;
			w_hold_reg <= 1'b0;
			waddr_reg <= 8'h00;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rresp_reg <= RESP_OKAY;
			rdata_reg <= 32'h0000_0000;
		end else begin
			aw_hold_reg <= aw_hold_next;
			w_hold_reg <= w_hold_next;
			waddr_reg <= waddr_next;
			wdata_reg <= wdata_next;
			wstrb_reg <= wstrb_next;
			awready_reg <= awready_next;
			wready_reg <= wready_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			arready_reg <= arready_next;
			rvalid_reg <= rvalid_next;
			rresp_reg <= rresp_next;
			rdata_reg <= rdata_next;
		end
	end

	function automatic logic addr_ok(input logic [IMSS_ADDR_W-1:0] a);
		addr_ok = (a == OFS_CTRL) || (a == OFS_FRAME) || (a == OFS_SCHED) ||
			(a == OFS_CNT01) || (a == OFS_CNT23) || (a == OFS_CNT45) ||
			(a == OFS_CNT67) || (a == OFS_INT_STAT) || (a == OFS_INT_MASK);
	endfunction

	function automatic logic [31:0] cnt_pair(input int lo);
		logic [31:0] v;
		v = 32'h0000_0000;
		v[IMSS_CNT_W-1:0] = count_reg[lo];
		v[CNT_HI_LSB +: IMSS_CNT_W] = count_reg[lo+1];
		cnt_pair = v;
	endfunction

	function automatic logic [31:0] read_word(input logic [IMSS_ADDR_W-1:0] a);
		logic [31:0] v;
		v = 32'h0000_0000;
		if (a == OFS_CTRL) begin
			v[CTRL_ACTIVE_BIT] = active_reg;
			v[CTRL_TOKEN_IN_BIT] = token_in_reg;
			v[CTRL_HALT_BIT] = halt_reg;
		end else if (a == OFS_FRAME) begin
			v[7:0] = frame_reg;
		end else if (a == OFS_SCHED) begin
			v[7:0] = mask_reg;
			v[31:SCHED_OUT_LSB] = outcome_flat;
		end else if (a == OFS_CNT01) begin
			v = cnt_pair(0);
		end else if (a == OFS_CNT23) begin
			v = cnt_pair(2);
		end else if (a == OFS_CNT45) begin
			v = cnt_pair(4);
		end else if (a == OFS_CNT67) begin
			v = cnt_pair(6);
		end else if (a == OFS_INT_STAT) begin
			v[IMSS_INT_W-1:0] = int_stat_reg;
		end else if (a == OFS_INT_MASK) begin
			v[IMSS_INT_W-1:0] = int_mask_reg;
		end
		read_word = v;
	endfunction

	assign wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
	assign wbits = wdata_reg & wmask;

	////////////////////////////////////////////////////////////////////////////////
	// Control, frame, schedule mask and interrupts
	assign mask_sw_set = (wr_en && waddr_reg == OFS_SCHED) ? wbits[7:0] : 8'h00;

	always_comb begin
		active_next = active_reg;
		token_in_next = token_in_reg;
		halt_next = halt_reg;
		frame_next = frame_reg;
		int_mask_next = int_mask_reg;
		int_stat_next = int_stat_reg;
		if (wr_en && waddr_reg == OFS_CTRL) begin
			if (wmask[CTRL_ACTIVE_BIT]) begin
				active_next = wbits[CTRL_ACTIVE_BIT];
				// Re-arming a halted descriptor also drops its halt
				if (wbits[CTRL_ACTIVE_BIT]) begin
					halt_next = 1'b0;
				end
			end
			if (wmask[CTRL_TOKEN_IN_BIT]) begin
				token_in_next = wbits[CTRL_TOKEN_IN_BIT];
			end
		end
		if (wr_en && waddr_reg == OFS_FRAME) begin
			frame_next = (frame_reg & ~wmask[7:0]) | wbits[7:0];
		end
		if (wr_en && waddr_reg == OFS_INT_MASK) begin
			int_mask_next = (int_mask_reg & ~wmask[IMSS_INT_W-1:0]) | wbits[IMSS_INT_W-1:0];
		end
		if (sif.rec_valid && sif.rec_halt) begin
			halt_next = 1'b1;
			active_next = 1'b0;
		end
		if (wr_en && waddr_reg == OFS_INT_STAT) begin
			int_stat_next = int_stat_reg & ~wbits[IMSS_INT_W-1:0];
		end
		// An event in the clearing cycle survives the clear
		int_stat_next = int_stat_next | int_event;
		irq_next = |(int_stat_next & int_mask_next);
	end

	always_comb begin
		int_event = 4'h0;
		int_event[INT_DONE_BIT] = sif.rec_valid;
		int_event[INT_ERR_BIT] = sif.rec_valid && (sif.rec_outcome != RST_OUTCOME);
		int_event[INT_HALT_BIT] = sif.rec_valid && sif.rec_halt;
		int_event[INT_FRAME_BIT] = sif.rec_valid && ((mask_reg & ~mask_hw_clr) == 8'h00);
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			active_reg <= 1'b0;
			token_in_reg <= 1'b0;
			halt_reg <= 1'b0;
			frame_reg <= RST_FRAME;
			int_mask_reg <= RST_INT_MASK;
			int_stat_reg <= 4'h0;
			irq_reg <= 1'b0;
		end else begin
			active_reg <= active_next;
			token_in_reg <= token_in_next;
			halt_reg <= halt_next;
			frame_reg <= frame_next;
			int_mask_reg <= int_mask_next;
			int_stat_reg <= int_stat_next;
			irq_reg <= irq_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Per-microframe mask bit, outcome and IN byte count
	genvar g;
	generate
		for (g = 0; g < IMSS_NUM_UF; g++) begin : g_uf
			logic hit;
			logic mask_bit_next;
			logic [IMSS_OUT_W-1:0] out_next;
			logic [IMSS_CNT_W-1:0] cnt_next;
			assign hit = sif.rec_valid && (sif.rec_idx == IMSS_UF_W'(g));
			assign mask_hw_clr[g] = hit;
			assign outcome_flat[g*IMSS_OUT_W +: IMSS_OUT_W] = outcome_reg[g];
			always_comb begin
				mask_bit_next = mask_reg[g];
				out_next = outcome_reg[g];
				cnt_next = count_reg[g];
				if (hit) begin
					mask_bit_next = 1'b0;
					out_next = sif.rec_outcome;
					if (token_in_reg) begin
						cnt_next = sif.rec_count;
					end
				end
				// A fresh request from software wins over the hardware clear
				if (mask_sw_set[g]) begin
					mask_bit_next = 1'b1;
				end
			end
			always_ff @(posedge ref_clk) begin
				if (reset) begin
					mask_reg[g] <= RST_MASK[g];
					outcome_reg[g] <= RST_OUTCOME;
					count_reg[g] <= RST_COUNT;
				end else begin
					mask_reg[g] <= mask_bit_next;
					outcome_reg[g] <= out_next;
					count_reg[g] <= cnt_next;
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Sequencer hookup
	assign sif.active = active_reg;
	assign sif.token_in = token_in_reg;
	assign sif.mask = mask_reg;
	// Low three bits of the frame field take no part in the match
	assign sif.frame_match = (frame_reg[FRAME_NUM_MSB:FRAME_NUM_LSB] == usb_frame_num);

	imss_uframe_seq u_seq (
		.ref_clk(ref_clk),
		.reset(reset),
		.sif(sif.seq),
		.usb_sof(usb_sof),
		.usb_uframe(usb_uframe),
		.xfer_done(xfer_done),
		.xfer_err(xfer_err),
		.xfer_babble(xfer_babble),
		.xfer_underrun(xfer_underrun),
		.xfer_stall(xfer_stall),
		.xfer_byte_count(xfer_byte_count),
		.xfer_start(xfer_start),
		.xfer_uframe(xfer_uframe),
		.xfer_is_in(xfer_is_in)
	);

	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rdata = rdata_reg;
	assign irq = irq_reg;
endmodule

/* File: src/imss_uframe_seq.sv */
// Microframe sequencer: starts one transfer per marked microframe and reports it.
// Assumes link strobes are on ref_clk and done follows each start exactly once.
`timescale 1ns/1ps
module imss_uframe_seq
	import imss_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	imss_sched_if.seq sif,
	input wire logic usb_sof,
	input wire logic [IMSS_UF_W-1:0] usb_uframe,
	input wire logic xfer_done,
	input wire logic xfer_err,
	input wire logic xfer_babble,
	input wire logic xfer_underrun,
	input wire logic xfer_stall,
	input wire logic [IMSS_CNT_W-1:0] xfer_byte_count,
	output logic xfer_start,
	output logic [IMSS_UF_W-1:0] xfer_uframe,
	output logic xfer_is_in
);
	imss_seq_e state_reg, state_next;
	logic start_reg, start_next;
	logic is_in_reg, is_in_next;
	logic [IMSS_UF_W-1:0] idx_reg, idx_next;
	logic rec_valid_reg, rec_valid_next;
	logic rec_halt_reg, rec_halt_next;
	logic [IMSS_OUT_W-1:0] outcome_reg, outcome_next;
	logic [IMSS_CNT_W-1:0] count_reg, count_next;

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		state_next = state_reg;
		start_next = 1'b0;
		is_in_next = is_in_reg;
		idx_next = idx_reg;
		rec_valid_next = 1'b0;
		rec_halt_next = 1'b0;
		outcome_next = outcome_reg;
		count_next = count_reg;
		case (state_reg)
			IMSS_SEQ_IDLE: begin
				// A start of microframe seen while busy is dropped, not queued
				// A stall just reported blocks starts until the cleared active flag lands
				if (usb_sof && sif.active && sif.frame_match && sif.mask[usb_uframe] &&
					!rec_halt_reg) begin
					start_next = 1'b1;
					idx_next = usb_uframe;
					is_in_next = sif.token_in;
					state_next = IMSS_SEQ_WAIT;
				end
			end
			IMSS_SEQ_WAIT: begin
				if (xfer_done) begin
					rec_valid_next = 1'b1;
					rec_halt_next = xfer_stall;
					outcome_next[OUT_ERR_BIT] = xfer_err;
					outcome_next[OUT_BABBLE_BIT] = xfer_babble & is_in_reg;
					outcome_next[OUT_UNDERRUN_BIT] = xfer_underrun & ~is_in_reg;
					count_next = xfer_byte_count;
					state_next = IMSS_SEQ_IDLE;
				end
			end
			default: state_next = IMSS_SEQ_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state_reg <= IMSS_SEQ_IDLE;
			start_reg <= 1'b0;
			is_in_reg <= 1'b0;
			idx_reg <= 3'h0;
			rec_valid_reg <= 1'b0;
			rec_halt_reg <= 1'b0;
			outcome_reg <= RST_OUTCOME;
			count_reg <= RST_COUNT;
		end else begin
			state_reg <= state_next;
			start_reg <= start_next;
			is_in_reg <= is_in_next;
			idx_reg <= idx_next;
			rec_valid_reg <= rec_valid_next;
			rec_halt_reg <= rec_halt_next;
			outcome_reg <= outcome_next;
			count_reg <= count_next;
		end
	end

	assign xfer_start = start_reg;
	assign xfer_uframe = idx_reg;
	assign xfer_is_in = is_in_reg;
	assign sif.rec_valid = rec_valid_reg;
	assign sif.rec_halt = rec_halt_reg;
	assign sif.rec_idx = idx_reg;
	assign sif.rec_outcome = outcome_reg;
	assign sif.rec_count = count_reg;
endmodule

/* File: verif/imss_link_model.sv */
// Model of a downstream isochronous endpoint answering each transfer start.
// Assumes the bench sets outcome flags and count before the start arrives.
`timescale 1ns/1ps
module imss_link_model
	import imss_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic xfer_start,
	input wire logic slow,
	input wire logic [3:0] fl,
	input wire logic [IMSS_CNT_W-1:0] cnt,
	output logic xfer_done,
	output logic xfer_err,
	output logic xfer_babble,
	output logic xfer_underrun,
	output logic xfer_stall,
	output logic [IMSS_CNT_W-1:0] xfer_byte_count
);
	logic [3:0] wait_reg;
	////////////////////////////////////////
	// One done per start, prompt or slow
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			wait_reg <= 4'h0;
			xfer_done <= 1'b0;
		end else begin
			wait_reg <= xfer_start ? (slow ? 4'h6 : 4'h1) : wait_reg - 4'(wait_reg != 4'h0);
			xfer_done <= wait_reg == 4'h1;
		end
	end
	// Qualifiers are junk outside done so the block must sample them with done
	assign {xfer_stall, xfer_underrun, xfer_babble, xfer_err} = xfer_done ? fl : ~fl;
	assign xfer_byte_count = xfer_done ? cnt : ~cnt;
endmodule

/* File: verif/imss_top_properties.sv */
// Concurrent checks on the ports of the microframe schedule block.
// Assumes one clock and a bench that keeps bready and rready high.
`timescale 1ns/1ps
module imss_top_properties
	import imss_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [IMSS_ADDR_W-1:0] s_axi_awaddr,
	input wire logic [31:0] s_axi_wdata,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic usb_sof,
	input wire logic [IMSS_UF_W-1:0] usb_uframe,
	input wire logic xfer_done,
	input wire logic xfer_stall,
	input wire logic xfer_start,
	input wire logic [IMSS_UF_W-1:0] xfer_uframe,
	input wire logic xfer_is_in,
	input wire logic irq
);
	logic pend_reg, pend_next, halt_reg, halt_next;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	////////////////////////////////////////
	// Only a control write that re-arms the descriptor ends the watch
	// Address and data of a write are taken at one edge by this block
	always_comb begin
		pend_next = xfer_start | (pend_reg & ~xfer_done);
		halt_next = (xfer_done & xfer_stall) | (halt_reg & ~(s_axi_awvalid & s_axi_awready &
			(s_axi_awaddr == OFS_CTRL) & s_axi_wdata[CTRL_ACTIVE_BIT]));
	end
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			pend_reg <= 1'b0;
			halt_reg <= 1'b0;
		end else begin
			pend_reg <= pend_next;
			halt_reg <= halt_next;
		end
	end
	////////////////////////////////////////
	uframe_sel_a: assert property (xfer_start |-> $past(usb_sof)
		&& xfer_uframe == $past(usb_uframe)) else $error("start without matching sof");
	start_pulse_a: assert property (xfer_start |=> !xfer_start)
		else $error("start longer than one cycle");
	start_hold_a: assert property (!xfer_start |-> $stable(xfer_uframe) && $stable(xfer_is_in))
		else $error("transfer tags changed without start");
	one_pending_a: assert property (xfer_start |-> !pend_reg)
		else $error("second start before done");
	halt_block_a: assert property (xfer_start |-> !halt_reg)
		else $error("start while halted");
	irq_cause_a: assert property ($rose(irq) |-> $past(xfer_done, 2)
		|| s_axi_bvalid || $past(s_axi_bvalid)) else $error("irq rose without cause");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	write_answer_a: assert property (s_axi_awvalid && s_axi_awready
		&& s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
endmodule

bind imss_top imss_top_properties imss_top_properties_inst (.ref_clk, .reset, .s_axi_awaddr,
	.s_axi_wdata, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .usb_sof, .usb_uframe, .xfer_done, .xfer_stall, .xfer_start, .xfer_uframe,
	.xfer_is_in, .irq);

/* File: verif/tb_imss_top.sv */
// Self-checking bench for the microframe schedule block over AXI4-Lite.
// Assumes the link model answers every start with exactly one done.
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_total++; \
	$display("mismatch at %0t: got %h want %h", $time, a, b); end end
module tb_imss_top import imss_pkg::*;;
	logic ref_clk, reset, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [IMSS_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, exp_s;
	logic [3:0] s_axi_wstrb, fl;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic usb_sof, xfer_done, xfer_err, xfer_babble, xfer_underrun, xfer_stall;
	logic xfer_start, xfer_is_in, irq, slow;
	logic [IMSS_UF_W-1:0] usb_uframe, xfer_uframe;
	logic [IMSS_FRM_W-1:0] usb_frame_num;
	logic [IMSS_CNT_W-1:0] xfer_byte_count, cnt;
	int err_total = 0;
	int checks_done = 0;
	int cyc = 0;
	////////////////////////////////////////
	imss_top imss_top_inst (.ref_clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .usb_sof, .usb_uframe, .usb_frame_num, .xfer_done,
		.xfer_err, .xfer_babble, .xfer_underrun, .xfer_stall, .xfer_byte_count, .xfer_start,
		.xfer_uframe, .xfer_is_in, .irq);
	imss_link_model imss_link_model_inst (.ref_clk, .reset, .xfer_start, .slow, .fl, .cnt,
		.xfer_done, .xfer_err, .xfer_babble, .xfer_underrun, .xfer_stall, .xfer_byte_count);
	////////////////////////////////////////
	task test_done;
		if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// Ready lines stay high, so a back-to-back call never toggles them in one step
	task automatic wr_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		logic pa, pw;
		pa = 1'b1;
		pw = 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (pa || pw) begin
			@(posedge ref_clk);
			if (pa && s_axi_awready) begin
				s_axi_awvalid <= 1'b0;
				pa = 1'b0;
			end
			if (pw && s_axi_wready) begin
				s_axi_wvalid <= 1'b0;
				pw = 1'b0;
			end
		end
		do @(posedge ref_clk); while (!s_axi_bvalid);
		`CHK(s_axi_bresp, r)
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge ref_clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge ref_clk); while (!s_axi_rvalid);
		`CHK(s_axi_rdata, d)
		`CHK(s_axi_rresp, r)
	endtask
	task automatic sof(input logic [2:0] uf, input logic exp, input logic dir);
		logic seen, dn;
		seen = 1'b0;
		dn = 1'b0;
		usb_uframe <= uf;
		usb_sof <= 1'b1;
		@(posedge ref_clk);
		usb_sof <= 1'b0;
		repeat (3) begin
			@(posedge ref_clk);
			seen = seen | xfer_start;
			dn = dn | (seen & xfer_done);
		end
		`CHK(seen, exp)
		if (seen) begin
			`CHK(xfer_uframe, uf)
			`CHK(xfer_is_in, dir)
			while (!dn) begin
				@(posedge ref_clk);
				dn = xfer_done;
			end
			repeat (3) @(posedge ref_clk);
		end
	endtask
	////////////////////////////////////////
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			test_done();
		end
	end
	initial begin
		reset = 1'b1;
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, usb_sof, slow} = '0;
		{s_axi_bready, s_axi_rready} = 2'h3;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, usb_uframe, fl, cnt} = '0;
		s_axi_wstrb = 4'hf;
		usb_frame_num = 5'h03;
		repeat (8) @(posedge ref_clk);
		reset <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rd_chk(OFS_CTRL, 32'h0, RESP_OKAY);
		rd_chk(OFS_FRAME, 32'h0, RESP_OKAY);
		rd_chk(OFS_SCHED, 32'h0, RESP_OKAY);
		rd_chk(OFS_INT_MASK, 32'h0, RESP_OKAY);
		rd_chk(8'h24, 32'h0, RESP_DECERR);
		wr_chk(8'h24, 32'hffff_ffff, RESP_DECERR);
		wr_chk(OFS_INT_MASK, 32'hf, RESP_OKAY);
		wr_chk(OFS_FRAME, 32'h1d, RESP_OKAY);
		s_axi_wstrb <= 4'h2;
		wr_chk(OFS_FRAME, 32'hff, RESP_OKAY);
		s_axi_wstrb <= 4'hf;
		rd_chk(OFS_FRAME, 32'h1d, RESP_OKAY);
		wr_chk(OFS_CTRL, 32'h3, RESP_OKAY);
		wr_chk(OFS_SCHED, 32'h55, RESP_OKAY);
		exp_s = 32'h0;
		// Alternating mask, errors on some slots, babble and underrun always offered
		for (int u = 0; u < 8; u++) begin
			fl <= {3'b011, u[1]};
			cnt <= 12'h100 + 12'(u);
			slow <= u[2];
			sof(3'(u), !u[0], 1'b1);
			if (!u[0]) exp_s = exp_s | ((32'h2 | 32'(u[1])) << (8 + 3 * u));
		end
		rd_chk(OFS_SCHED, exp_s, RESP_OKAY);
		for (int k = 0; k < 4; k++) begin
			rd_chk(8'(OFS_CNT01 + 4 * k), 32'h100 + 32'(2 * k), RESP_OKAY);
		end
		`CHK(irq, 1'b1)
		rd_chk(OFS_INT_STAT, 32'hb, RESP_OKAY);
		wr_chk(OFS_INT_STAT, 32'hf, RESP_OKAY);
		rd_chk(OFS_INT_STAT, 32'h0, RESP_OKAY);
		`CHK(irq, 1'b0)
		usb_frame_num <= 5'h04;
		wr_chk(OFS_SCHED, 32'h1, RESP_OKAY);
		sof(3'h0, 1'b0, 1'b1);
		rd_chk(OFS_SCHED, exp_s | 32'h1, RESP_OKAY);
		usb_frame_num <= 5'h03;
		wr_chk(OFS_CTRL, 32'h1, RESP_OKAY);
		fl <= 4'h7;
		cnt <= 12'h7ff;
		sof(3'h0, 1'b1, 1'b0);
		exp_s = (exp_s & ~32'h700) | 32'h500;
		rd_chk(OFS_SCHED, exp_s, RESP_OKAY);
		rd_chk(OFS_CNT01, 32'h100, RESP_OKAY);
		rd_chk(OFS_INT_STAT, 32'hb, RESP_OKAY);
		wr_chk(OFS_INT_STAT, 32'hf, RESP_OKAY);
		wr_chk(OFS_CTRL, 32'h3, RESP_OKAY);
		wr_chk(OFS_SCHED, 32'h6, RESP_OKAY);
		fl <= 4'h8;
		sof(3'h1, 1'b1, 1'b1);
		rd_chk(OFS_CTRL, 32'h6, RESP_OKAY);
		rd_chk(OFS_INT_STAT, 32'h5, RESP_OKAY);
		wr_chk(OFS_INT_MASK, 32'h0, RESP_OKAY);
		repeat (2) @(posedge ref_clk);
		`CHK(irq, 1'b0)
		wr_chk(OFS_INT_MASK, 32'h4, RESP_OKAY);
		repeat (2) @(posedge ref_clk);
		`CHK(irq, 1'b1)
		wr_chk(OFS_INT_STAT, 32'h4, RESP_OKAY);
		repeat (2) @(posedge ref_clk);
		`CHK(irq, 1'b0)
		rd_chk(OFS_INT_STAT, 32'h1, RESP_OKAY);
		sof(3'h2, 1'b0, 1'b1);
		fl <= 4'h0;
		cnt <= 12'h0aa;
		wr_chk(OFS_CTRL, 32'h3, RESP_OKAY);
		sof(3'h2, 1'b1, 1'b1);
		rd_chk(OFS_CNT23, 32'h0aa, RESP_OKAY);
		rd_chk(OFS_SCHED, exp_s & ~(32'h7 << 14), RESP_OKAY);
		test_done();
	end
endmodule
